// File: logic/psw_host.sv
// Host controller that writes a pseudo-static RAM and manages power-down
// Function
// - Write pulse starts at the last enable falling; hold it at least 40 ns.
// - Recovery starts at the first enable rising; zero minimum.
// - Each write cycle lasts pulse plus recovery and at least 65 ns.
// - With select low and address fixed, a write cycle stays under 1000 ns.
// - Byte-mask setup to later select/write falling edge, minimum -5 ns.
// - Byte-mask hold from earlier select/write rising edge, minimum -5 ns.
// - Output enable high within 5 ns of select falling, else read starts.
// - Output enable high by address change; after read, wait read cycle.
// - Write-enable high intervals stay between 7.5 ns and 1000 ns.
// - Two byte write pulses overlap at least 30 ns.
// - Power-down: select low 10 ns setup, held low at least 65 ns.
// - Select held high 300 us after power-down exit or power-up.
// - With partial power-down programmed, exit hold is only 1 us.
// - After power-up keep power-down select low at least 50 us.
// - Write enable stays valid 10 ns after select rises for standby.
// - Output enable stays valid 10 ns after select rises for standby.
`timescale 1ns/100ps
`default_nettype none

module psw_host
  import psw_pkg::*;
#(
  parameter int unsigned EXIT_SLEEP_CYCLES = C_EXIT_SLEEP,
  parameter int unsigned EXIT_PARTIAL_CYCLES = C_EXIT_PARTIAL,
  parameter int unsigned POWERUP_LOW_CYCLES = C_POWERUP_LOW
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic req_valid,
  output logic req_ready,
  input wire psw_req_type req,
  input wire logic pd_enter,
  input wire logic pd_exit,
  input wire logic partial_mode,
  output logic powered_down,
  output psw_pins_type pins,
  output logic [ADDR_W-1:0] mem_addr,
  output logic [DATA_W-1:0] mem_data_out,
  output logic mem_data_oe
);

  psw_state_type state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [CNT_W-1:0] cyc_reg, cyc_next;
  psw_pins_type pins_reg, pins_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [DATA_W-1:0] data_reg, data_next;
  logic oe_reg, oe_next;
  logic partial_reg, partial_next;
  logic pd_reg, pd_next;

  function automatic logic [CNT_W-1:0] cw(input int unsigned v);
    return v[CNT_W-1:0];
  endfunction : cw

  function automatic logic [CNT_W-1:0] dec(input logic [CNT_W-1:0] c);
    return (c == '0) ? c : c - cw(1);
  endfunction : dec

  // Cycles of the pulse, widened to the byte overlap; recovery widened so the whole cycle reaches its minimum
  localparam int unsigned PULSE_C =
    (C_WRITE_PULSE > C_OVERLAP) ? C_WRITE_PULSE : C_OVERLAP;
  localparam int unsigned REST_C = C_WRITE_CYCLE - PULSE_C - 1;
  localparam int unsigned RECOV_C =
    (REST_C > C_WRITE_RECOVERY) ? REST_C : C_WRITE_RECOVERY;

  always_comb
  begin
    state_next = state_reg;
    cnt_next = dec(cnt_reg);
    cyc_next = cyc_reg + cw(1);
    pins_next = pins_reg;
    addr_next = addr_reg;
    data_next = data_reg;
    oe_next = oe_reg;
    partial_next = partial_reg;
    pd_next = pd_reg;
    case (state_reg)
      ST_POWERUP:
      begin
        if (cnt_reg == '0)
        begin
          pins_next.power_down_select = 1'h1;
          cnt_next = cw(EXIT_SLEEP_CYCLES);
          state_next = ST_EXIT_WAIT;
        end
      end
      ST_EXIT_WAIT:
      begin
        if (cnt_reg == '0)
        begin
          pd_next = 1'h0;
          state_next = ST_IDLE;
        end
      end
      ST_IDLE:
      begin
        if (pd_enter)
        begin
          partial_next = partial_mode;
          cnt_next = cw(C_PD_SETUP);
          state_next = ST_PD_SETUP;
        end
        else if (req_valid)
        begin
          // output enable high before address moves
          pins_next.output_enable_n = 1'h1;
          // output enable already high as select falls
          pins_next.chip_select_n = 1'h0;
          // byte mask set with select, before write enable
          pins_next.lower_byte_enable_n = ~req.byte_en[0];
          pins_next.upper_byte_enable_n = ~req.byte_en[1];
          addr_next = req.addr;
          data_next = req.data;
          oe_next = 1'h1;
          cyc_next = '0;
          state_next = ST_SETUP;
        end
      end
      ST_SETUP:
      begin
        // write enable falls last, opening the pulse
        pins_next.write_enable_n = 1'h0;
        // both bytes share one pulse, full overlap
        cnt_next = cw(PULSE_C - 1);
        state_next = ST_PULSE;
      end
      ST_PULSE:
      begin
        if (cnt_reg == '0)
        begin
          // high gap spans recovery to next pulse
          // write enable rises first, starting recovery
          pins_next.write_enable_n = 1'h1;
          // remainder keeps the cycle at minimum length
          cnt_next = cw(RECOV_C);
          state_next = ST_RECOVER;
        end
      end
      ST_RECOVER:
      begin
        // cycle bound two cycles under the maximum
        if (cnt_reg == '0 || cyc_reg >= cw(C_CYCLE_MAX - 2))
        begin
          // byte mask kept past select rising, until the standby hold ends
          pins_next.chip_select_n = 1'h1;
          cnt_next = cw(C_STANDBY_HOLD);
          state_next = ST_HOLD;
        end
      end
      ST_HOLD:
      begin
        // write enable held through standby entry
        // output enable held through standby entry
        if (cnt_reg == '0)
        begin
          pins_next.lower_byte_enable_n = 1'h1;
          pins_next.upper_byte_enable_n = 1'h1;
          oe_next = 1'h0;
          state_next = ST_IDLE;
        end
      end
      ST_PD_SETUP:
      begin
        if (cnt_reg == '0)
        begin
          pins_next.power_down_select = 1'h0;
          pd_next = 1'h1;
          cnt_next = cw(C_PD_HOLD);
          state_next = ST_PD_HOLD;
        end
      end
      ST_PD_HOLD:
      begin
        if (cnt_reg == '0)
          state_next = ST_PD;
      end
      ST_PD:
      begin
        if (pd_exit)
        begin
          pins_next.power_down_select = 1'h1;
          // short exit wait in partial mode
          cnt_next = partial_reg ? cw(EXIT_PARTIAL_CYCLES)
                                 : cw(EXIT_SLEEP_CYCLES);
          state_next = ST_EXIT_WAIT;
        end
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_reg <= ST_POWERUP;
      cnt_reg <= cw(POWERUP_LOW_CYCLES);
      cyc_reg <= '0;
      pins_reg <= '{chip_select_n: RST_SELECT_N,
                    power_down_select: RST_PD_SELECT,
                    write_enable_n: 1'h1,
                    output_enable_n: 1'h1,
                    lower_byte_enable_n: 1'h1,
                    upper_byte_enable_n: 1'h1};
      addr_reg <= '0;
      data_reg <= '0;
      oe_reg <= 1'h0;
      partial_reg <= 1'h0;
      pd_reg <= 1'h1;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      cyc_reg <= cyc_next;
      pins_reg <= pins_next;
      addr_reg <= addr_next;
      data_reg <= data_next;
      oe_reg <= oe_next;
      partial_reg <= partial_next;
      pd_reg <= pd_next;
    end
  end

  assign req_ready = (state_reg == ST_IDLE) && !pd_enter;
  assign powered_down = pd_reg;
  assign pins = pins_reg;
  assign mem_addr = addr_reg;
  assign mem_data_out = data_reg;
  assign mem_data_oe = oe_reg;

endmodule : psw_host

`default_nettype wire

// File: logic/psw_pkg.sv
// Package: timing constants, states and carrier types for the pseudo-static RAM write host
package psw_pkg;

  localparam int unsigned CLK_PERIOD_PS = 4000;

  // Times in their printed units
  localparam int unsigned T_WRITE_PULSE_NS = 40;
  localparam int unsigned T_WRITE_RECOVERY_NS = 0;
  localparam int unsigned T_WRITE_CYCLE_NS = 65;
  localparam int unsigned T_CYCLE_MAX_NS = 1000;
  localparam int unsigned T_WE_HIGH_MIN_PS = 7500;
  localparam int unsigned T_OVERLAP_NS = 30;
  localparam int unsigned T_PD_SETUP_NS = 10;
  localparam int unsigned T_PD_HOLD_NS = 65;
  localparam int unsigned T_EXIT_SLEEP_US = 300;
  localparam int unsigned T_EXIT_PARTIAL_US = 1;
  localparam int unsigned T_POWERUP_LOW_US = 50;
  localparam int unsigned T_STANDBY_HOLD_NS = 10;
  localparam int unsigned T_READ_CYCLE_NS = 65;

  function automatic int unsigned cyc_up(input int unsigned ps);
    int unsigned c;
    c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_up

  // Least times rounded up to whole cycles; the cycle maximum rounded down
  localparam int unsigned C_WRITE_PULSE = cyc_up(T_WRITE_PULSE_NS * 1000);
  localparam int unsigned C_WRITE_RECOVERY = cyc_up(T_WRITE_RECOVERY_NS * 1000);
  localparam int unsigned C_WRITE_CYCLE = cyc_up(T_WRITE_CYCLE_NS * 1000);
  localparam int unsigned C_CYCLE_MAX = T_CYCLE_MAX_NS * 1000 / CLK_PERIOD_PS;
  localparam int unsigned C_WE_HIGH = cyc_up(T_WE_HIGH_MIN_PS);
  localparam int unsigned C_OVERLAP = cyc_up(T_OVERLAP_NS * 1000);
  localparam int unsigned C_PD_SETUP = cyc_up(T_PD_SETUP_NS * 1000);
  localparam int unsigned C_PD_HOLD = cyc_up(T_PD_HOLD_NS * 1000);
  localparam int unsigned C_EXIT_SLEEP = cyc_up(T_EXIT_SLEEP_US * 1000000);
  localparam int unsigned C_EXIT_PARTIAL = cyc_up(T_EXIT_PARTIAL_US * 1000000);
  localparam int unsigned C_POWERUP_LOW = cyc_up(T_POWERUP_LOW_US * 1000000);
  localparam int unsigned C_STANDBY_HOLD = cyc_up(T_STANDBY_HOLD_NS * 1000);
  localparam int unsigned C_READ_CYCLE = cyc_up(T_READ_CYCLE_NS * 1000);

  localparam int unsigned ADDR_W = 21;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned CNT_W = 18;

  // Pin levels after reset: deselected, power-down asserted
  localparam logic RST_SELECT_N = 1'h1;
  localparam logic RST_PD_SELECT = 1'h0;

  typedef enum logic [3:0] {
    ST_POWERUP = 4'h0,
    ST_EXIT_WAIT = 4'h1,
    ST_IDLE = 4'h3,
    ST_SETUP = 4'h2,
    ST_PULSE = 4'h6,
    ST_RECOVER = 4'h7,
    ST_HOLD = 4'h5,
    ST_PD_SETUP = 4'h4,
    ST_PD_HOLD = 4'hC,
    ST_PD = 4'hD
  } psw_state_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [1:0] byte_en;
  } psw_req_type;

  typedef struct packed {
    logic chip_select_n;
    logic power_down_select;
    logic write_enable_n;
    logic output_enable_n;
    logic lower_byte_enable_n;
    logic upper_byte_enable_n;
  } psw_pins_type;

endpackage : psw_pkg

// File: dv/psw_host_monitor.sv
// Checker of host pin timing
`timescale 1ns/100ps
`default_nettype none
module psw_host_monitor
  import psw_pkg::*;
#(
  parameter int unsigned EXIT_SLEEP_CYCLES = C_EXIT_SLEEP,
  parameter int unsigned EXIT_PARTIAL_CYCLES = C_EXIT_PARTIAL,
  parameter int unsigned POWERUP_LOW_CYCLES = C_POWERUP_LOW
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire psw_req_type req,
  input wire logic pd_enter,
  input wire logic pd_exit,
  input wire logic partial_mode,
  input wire logic powered_down,
  input wire psw_pins_type pins,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic [DATA_W-1:0] mem_data_out,
  input wire logic mem_data_oe
);
  logic [CNT_W-1:0] lo_reg, hi_reg, cs_reg, lim;
  logic part_reg, boot_reg;
  wire logic pds = pins.power_down_select;
  wire logic we_n = pins.write_enable_n;
  assign lim = part_reg ? CNT_W'(EXIT_PARTIAL_CYCLES) : CNT_W'(EXIT_SLEEP_CYCLES);
  always_ff @(posedge clk)
  begin
    lo_reg <= (reset || pds) ? '0 : lo_reg + 1'b1;
    hi_reg <= (reset || !pds) ? '0 : hi_reg + 1'b1;
    cs_reg <= (reset || pins.chip_select_n) ? '0 : cs_reg + 1'b1;
    part_reg <= reset ? 1'b0 : (pd_enter && !powered_down) ? partial_mode : part_reg;
    boot_reg <= reset ? 1'b1 : (pds ? 1'b0 : boot_reg);
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_we_pulse_len: assert property ($fell(we_n) |-> (!we_n)[*8] ##1 (!we_n)[*2]) else $error("write pulse too short");
  a_we_in_select: assert property (!we_n |-> !pins.chip_select_n && pds) else $error("write pulse outside select");
  a_we_high_gap: assert property ($rose(we_n) |-> we_n[*2]) else $error("write enable high gap too short");
  a_cycle_span: assert property ($rose(pins.chip_select_n) |-> cs_reg >= C_WRITE_CYCLE && cs_reg < C_CYCLE_MAX) else $error("write cycle length wrong");
  a_no_read: assert property (pins.output_enable_n) else $error("output enable driven low");
  a_mask_steady: assert property (!we_n |-> $stable({pins.lower_byte_enable_n, pins.upper_byte_enable_n}) && $stable(mem_addr) && $stable(mem_data_out)) else $error("mask or data moved in pulse");
  a_request_taken: assert property (req_valid && req_ready |=> !pins.chip_select_n && mem_data_oe && mem_addr == $past(req.addr) && mem_data_out == $past(req.data) && {pins.upper_byte_enable_n, pins.lower_byte_enable_n} == ~$past(req.byte_en) ##1 !we_n) else $error("request not placed on pins");
  a_standby_hold: assert property ($rose(pins.chip_select_n) |-> we_n[*3]) else $error("write enable moved at standby");
  a_pd_entry: assert property ($fell(pds) |-> $past(pins.chip_select_n, 3) && (!pds)[*8] ##1 (!pds)[*8] ##1 !pds) else $error("power-down entry timing");
  a_exit_wait: assert property ($fell(pins.chip_select_n) |-> hi_reg >= lim) else $error("select too early after exit");
  a_powerup_low: assert property ($rose(pds) && boot_reg |-> lo_reg >= POWERUP_LOW_CYCLES) else $error("power-up low too short");
  a_ready_gate: assert property (req_ready |-> !powered_down && !pd_enter && pins.chip_select_n) else $error("ready while busy");
  c_masked: cover property (req_valid && req_ready && req.byte_en == 2'h0);
  c_partial: cover property ($fell(pds) && part_reg);
  c_exit: cover property ($rose(pds) && !boot_reg);
endmodule : psw_host_monitor
bind psw_host psw_host_monitor #(.EXIT_SLEEP_CYCLES(EXIT_SLEEP_CYCLES),
  .EXIT_PARTIAL_CYCLES(EXIT_PARTIAL_CYCLES),
  .POWERUP_LOW_CYCLES(POWERUP_LOW_CYCLES)) psw_host_monitor_inst (
  .clk(clk), .reset(reset), .req_valid(req_valid), .req_ready(req_ready),
  .req(req), .pd_enter(pd_enter), .pd_exit(pd_exit),
  .partial_mode(partial_mode), .powered_down(powered_down), .pins(pins),
  .mem_addr(mem_addr), .mem_data_out(mem_data_out),
  .mem_data_oe(mem_data_oe));
`default_nettype wire

// File: dv/psw_dev_model.sv
// Behavioural pseudo-static RAM die driven by the host
`timescale 1ns/100ps
`default_nettype none
module psw_dev_model
  import psw_pkg::*;
(
  input wire psw_pins_type pins,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic [DATA_W-1:0] mem_data_out,
  input wire logic mem_data_oe,
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic [DATA_W-1:0] rd_data,
  output logic [7:0] viol
);
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
  logic [1:0] be_n;
  logic armed = 1'b0;
  logic wrote = 1'b0;
  logic rd_kick = 1'b0;
  logic [7:0] viol_wr = 8'h00;
  logic [7:0] viol_sb = 8'h00;
  realtime t0;
  realtime t_cs;
  // Output enable low would start a read instead
  wire logic act = !pins.chip_select_n && !pins.write_enable_n &&
    pins.power_down_select && pins.output_enable_n &&
    !(pins.lower_byte_enable_n && pins.upper_byte_enable_n);
  assign viol = viol_wr + viol_sb;
  // Pulse starts at the last enable falling
  always @(posedge act)
  begin
    t0 = $realtime;
    be_n = {pins.upper_byte_enable_n, pins.lower_byte_enable_n};
    armed = 1'b1;
  end
  // Capture at the first enable rising
  always @(negedge act)
  begin
    if (armed)
    begin
      armed = 1'b0;
      wrote = 1'b1;
      if ($realtime - t0 < T_WRITE_PULSE_NS || !mem_data_oe)
        viol_wr = viol_wr + 8'h01;
      if (!mem.exists(mem_addr))
        mem[mem_addr] = 16'h0000;
      if (!be_n[0])
        mem[mem_addr][7:0] = mem_data_out[7:0];
      if (!be_n[1])
        mem[mem_addr][15:8] = mem_data_out[15:8];
      rd_kick = ~rd_kick;
    end
  end
  // Enables rest after select rises, else standby is late
  always @(posedge pins.chip_select_n)
    t_cs = $realtime;
  always @(pins.write_enable_n or pins.output_enable_n)
  begin
    if (wrote && pins.chip_select_n &&
        $realtime - t_cs < T_STANDBY_HOLD_NS)
      viol_sb = viol_sb + 8'h01;
  end
  always @(rd_addr or rd_kick)
    rd_data = mem.exists(rd_addr) ? mem[rd_addr] : 16'h0000;
endmodule : psw_dev_model
`default_nettype wire

// File: dv/psw_host_tb_top.sv
// Random and corner writes plus power-down runs against the device model
`timescale 1ns/100ps
`default_nettype none
module psw_host_tb_top;
  import psw_pkg::*;
  localparam int unsigned SLP = 20;
  localparam int unsigned PRT = 5;
  logic clk = 1'b0, reset = 1'b1, req_valid = 1'b0, pd_enter = 1'b0;
  logic pd_exit = 1'b0, partial_mode = 1'b0, req_ready, powered_down, oe;
  psw_req_type req = '0;
  psw_pins_type pins;
  logic [ADDR_W-1:0] mem_addr, rd_addr = '0;
  logic [DATA_W-1:0] mem_data_out, rd_data;
  logic [7:0] viol;
  logic [DATA_W-1:0] exp_mem [logic [ADDR_W-1:0]];
  int fails = 0, total_checks = 0;
  always #2 clk = ~clk;
  psw_host #(.EXIT_SLEEP_CYCLES(SLP), .EXIT_PARTIAL_CYCLES(PRT),
    .POWERUP_LOW_CYCLES(10)) psw_host_inst (.clk(clk), .reset(reset),
    .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .pd_enter(pd_enter), .pd_exit(pd_exit), .partial_mode(partial_mode),
    .powered_down(powered_down), .pins(pins), .mem_addr(mem_addr),
    .mem_data_out(mem_data_out), .mem_data_oe(oe));
  psw_dev_model psw_dev_model_inst (.pins(pins), .mem_addr(mem_addr),
    .mem_data_out(mem_data_out), .mem_data_oe(oe), .rd_addr(rd_addr),
    .rd_data(rd_data), .viol(viol));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report
  function automatic logic [15:0] merge(input logic [15:0] o, d,
    input logic [1:0] be);
    return {be[1] ? d[15:8] : o[15:8], be[0] ? d[7:0] : o[7:0]};
  endfunction : merge
  task automatic wait_for(ref logic s, input logic v, output int n);
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (s !== v && n < 5000);
    if (n >= 5000)
      check(32'h0, 32'h1);
  endtask : wait_for
  task automatic wr(input logic [20:0] a, logic [15:0] d, logic [1:0] be);
    int n;
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{addr: a, data: d, byte_en: be};
    wait_for(req_ready, 1'b1, n);
    @(posedge clk);
    req_valid <= 1'b0;
    exp_mem[a] = merge(exp_mem.exists(a) ? exp_mem[a] : 16'h0, d, be);
  endtask : wr
  task automatic pd_run(input logic part);
    int n;
    int unsigned lim;
    lim = part ? PRT : SLP;
    @(posedge clk);
    partial_mode <= part;
    pd_enter <= 1'b1;
    wait_for(powered_down, 1'b1, n);
    check(pins.power_down_select, 1'b0);
    @(posedge clk);
    pd_enter <= 1'b0;
    repeat (30) @(posedge clk);
    pd_exit <= 1'b1;
    wait_for(powered_down, 1'b0, n);
    @(posedge clk);
    pd_exit <= 1'b0;
    check(n > lim && n < lim + 10, 1'b1);
    $display("power-down test done");
  endtask : pd_run
  initial
  begin
    #100000;
    fails++;
    final_report();
  end
  initial
  begin
    int i, n;
    void'($urandom(32'hE3397B27));
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    check(pins.power_down_select, 1'b0);
    wait_for(req_ready, 1'b1, n);
    check(n > 10 + SLP, 1'b1);
    for (i = 0; i < 8; i++)
      wr(21'(i), 16'($urandom), 2'h3);
    wr(21'h1FFFFF, 16'hA5C3, 2'h3);
    wr(21'h1FFFFF, 16'h0000, 2'h0);
    repeat (40) wr(21'($urandom_range(7)), 16'($urandom), 2'($urandom));
    $display("write test done");
    pd_run(1'b0);
    pd_run(1'b1);
    wr(21'h3, 16'h5AA5, 2'h2);
    wait_for(req_ready, 1'b1, n);
    foreach (exp_mem[a])
    begin
      @(posedge clk);
      rd_addr <= a;
      @(negedge clk);
      check(rd_data, exp_mem[a]);
    end
    check(viol, 8'h00);
    $display("readback test done");
    final_report();
  end
endmodule : psw_host_tb_top
`default_nettype wire
